// ---- dv/cie_core_exec_assertions.sv ----
// checker for the instruction subset execution block
// assumes it is bound to cie_core_exec and sees only that module's ports
`default_nettype none
module cie_core_exec_chk
  import cie_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // instruction issue
  input wire logic issue,
  input wire cie_op_t op,
  input wire logic [CIE_DATA_W-1:0] literal,
  input wire logic [CIE_ADDR_W-1:0] file_addr,
  input wire logic dest_file,
  input wire logic busy,
  // register file
  input wire logic [CIE_DATA_W-1:0] file_rdata,
  input wire logic [CIE_ADDR_W-1:0] file_waddr,
  input wire logic [CIE_DATA_W-1:0] file_wdata,
  input wire logic file_we,
  // stack, program counter and watchdog
  input wire logic [CIE_PC_W-1:0] stack_head,
  input wire logic [CIE_PC_W-1:0] pc_load_val,
  input wire logic stack_pop,
  input wire logic pc_load,
  input wire logic watchdog_counter_clr,
  input wire logic watchdog_prescaler_clr,
  // status
  input wire logic [CIE_DATA_W-1:0] acc,
  input wire logic carry_flag,
  input wire logic nibble_borrow_flag,
  input wire logic zero_flag,
  input wire logic timeout_flag,
  input wire logic powerdown_flag,
  input wire logic halted,
  input wire logic osc_run
);
  default clocking @(posedge clk); endclocking
  default disable iff rst;
  logic tk;
  logic sub;
  logic alu_op;
  logic to_file;
  logic ge_full;
  logic ge_low;
  logic res_zero;
  logic [CIE_DATA_W-1:0] src;
  logic [CIE_DATA_W-1:0] res;
  // expected result, independent of the design's alu
  assign tk = issue && !busy;
  assign sub = op inside {CIE_OP_LITERAL_MINUS_ACC, CIE_OP_FILE_MINUS_ACC};
  assign alu_op = op > CIE_OP_HALT;
  assign to_file = dest_file && op > CIE_OP_LITERAL_XOR_ACC;
  assign src = (op < CIE_OP_FILE_MINUS_ACC) ? literal : file_rdata;
  assign res = sub ? src - acc
    : (op == CIE_OP_NIBBLE_EXCHANGE ? {src[3:0], src[7:4]} : src ^ acc);
  assign ge_full = src >= acc;
  assign ge_low = src[3:0] >= acc[3:0];
  assign res_zero = res == CIE_ZERO;
  ////////////////////////////////////////////////////////////
  a_exit_pop: assert property (tk && op == CIE_OP_SUB_EXIT |=> stack_pop && pc_load
    && pc_load_val == $past(stack_head) && $stable(zero_flag) && $stable(carry_flag)
    && $stable(nibble_borrow_flag)) else $error("exit pc load wrong");
  a_exit_two_cycles: assert property (tk && op == CIE_OP_SUB_EXIT |=>
    busy ##1 !busy) else $error("exit length wrong");
  a_halt_flags: assert property (tk && op == CIE_OP_HALT |=>
    !powerdown_flag && timeout_flag) else $error("halt flags wrong");
  a_halt_wdt_clear: assert property (tk && op == CIE_OP_HALT |=>
    watchdog_counter_clr && watchdog_prescaler_clr) else $error("watchdog not cleared");
  a_halt_osc_stop: assert property (tk && op == CIE_OP_HALT |=>
    halted && !osc_run) else $error("halt state wrong");
  a_acc_result: assert property (tk && alu_op && !to_file |=>
    acc == $past(res) && !file_we) else $error("acc result wrong");
  a_file_result: assert property (tk && to_file |=> file_we
    && file_wdata == $past(res) && file_waddr == $past(file_addr))
    else $error("file write wrong");
  a_sub_borrow: assert property (tk && sub |=> carry_flag == $past(ge_full)
    && nibble_borrow_flag == $past(ge_low)) else $error("borrow flags wrong");
  a_zero_flag: assert property (tk && alu_op && op != CIE_OP_NIBBLE_EXCHANGE |=>
    zero_flag == $past(res_zero)) else $error("zero flag wrong");
  a_flags_kept: assert property (tk && alu_op && !sub |=>
    $stable(carry_flag) && $stable(nibble_borrow_flag)) else $error("flags changed");
  a_strobe_single: assert property (stack_pop || watchdog_counter_clr |=>
    !stack_pop && !watchdog_counter_clr) else $error("strobe held too long");
  a_busy_refuse: assert property (busy |=> $stable(acc) && !file_we)
    else $error("request taken while busy");
endmodule
bind cie_core_exec cie_core_exec_chk i_chk (.*);
`default_nettype wire

// ---- dv/cie_core_exec_bench.sv ----
// self-checking bench for the instruction subset execution block
// assumes a combinational register file read, modelled by driving file_rdata
`default_nettype none
module cie_core_exec_bench
  import cie_pkg::*;
();
  timeunit 1ns;
  timeprecision 1ns;
  logic clk, rst, issue, dest_file, busy, wake, file_we, stack_pop, pc_load;
  logic watchdog_counter_clr, watchdog_prescaler_clr, carry_flag, nibble_borrow_flag, zero_flag;
  logic timeout_flag, powerdown_flag, halted, osc_run;
  logic [7:0] literal, file_rdata, file_wdata, acc, ea;
  logic [6:0] file_addr, file_waddr;
  logic [12:0] stack_head, pc_load_val;
  logic ec, edc, ez;
  cie_op_t op;
  int bad_count, total_checks;
  cie_core_exec i_dut (.*);
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  ////////////////////////////////////////////////////////////
  task automatic chk(logic [15:0] seen, logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  // one accumulator operation, issued alone, against a reference worked out here
  task automatic run(cie_op_t o, logic [7:0] k, logic [7:0] f, logic d);
    logic [7:0] s, r;
    logic sb, wr;
    s = (o < CIE_OP_FILE_MINUS_ACC) ? k : f;
    sb = o inside {CIE_OP_LITERAL_MINUS_ACC, CIE_OP_FILE_MINUS_ACC};
    r = sb ? s - ea : (o == CIE_OP_NIBBLE_EXCHANGE ? {s[3:0], s[7:4]} : s ^ ea);
    wr = d && o > CIE_OP_LITERAL_XOR_ACC;
    if (sb) {ec, edc} = {s >= ea, s[3:0] >= ea[3:0]};
    if (o != CIE_OP_NIBBLE_EXCHANGE) ez = (r == 8'h00);
    if (!wr) ea = r;
    @(negedge clk);
    issue = 1'b1;
    op = o;
    {literal, file_rdata, dest_file, file_addr} = {k, f, d, f[6:0]};
    @(negedge clk);
    issue = 1'b0;
    chk(file_we, wr);
    chk({file_waddr, file_wdata} & {15{wr}}, {f[6:0], r} & {15{wr}});
    chk(acc, ea);
    chk({carry_flag, nibble_borrow_flag, zero_flag}, {ec, edc, ez});
  endtask
  ////////////////////////////////////////////////////////////
  initial begin
    {rst, issue, dest_file, wake, literal, file_rdata, file_addr, stack_head} = '1;
    op = CIE_OP_NONE;
    {ea, ec, edc, ez} = '0;
    repeat (8) @(negedge clk);
    {rst, issue, dest_file, wake} = '0;
    chk({acc, timeout_flag, powerdown_flag, osc_run, busy}, {ea, 4'hE});
    run(CIE_OP_LITERAL_MINUS_ACC, 8'h05, 8'h00, 1'b0);
    run(CIE_OP_LITERAL_MINUS_ACC, 8'h03, 8'h00, 1'b1);
    run(CIE_OP_LITERAL_XOR_ACC, 8'hFE, 8'h00, 1'b0);
    run(CIE_OP_FILE_MINUS_ACC, 8'h00, 8'h00, 1'b1);
    run(CIE_OP_LITERAL_XOR_ACC, 8'h3C, 8'h00, 1'b0);
    run(CIE_OP_FILE_XOR_ACC, 8'h00, 8'hA5, 1'b1);
    run(CIE_OP_FILE_XOR_ACC, 8'h00, 8'h3C, 1'b0);
    run(CIE_OP_NIBBLE_EXCHANGE, 8'h00, 8'hA5, 1'b1);
    run(CIE_OP_NIBBLE_EXCHANGE, 8'h00, 8'h12, 1'b0);
    run(CIE_OP_FILE_MINUS_ACC, 8'h00, 8'h20, 1'b0);
    run(CIE_OP_LITERAL_MINUS_ACC, 8'hFF, 8'h00, 1'b0);
    // exit with a second request held up behind it, which must be refused
    stack_head = 13'h1ABC;
    @(negedge clk);
    issue = 1'b1;
    op = CIE_OP_SUB_EXIT;
    @(negedge clk);
    op = CIE_OP_LITERAL_XOR_ACC;
    literal = 8'hFF;
    chk({stack_pop, pc_load, busy, pc_load_val}, {3'h7, 13'h1ABC});
    @(negedge clk);
    issue = 1'b0;
    chk(busy, 1'b0);
    chk({stack_pop, pc_load}, 2'h0);
    chk({acc, carry_flag, nibble_borrow_flag, zero_flag}, {ea, ec, edc, ez});
    // halt, then a refused request, then wake
    @(negedge clk);
    issue = 1'b1;
    op = CIE_OP_HALT;
    @(negedge clk);
    op = CIE_OP_LITERAL_XOR_ACC;
    chk({powerdown_flag, timeout_flag}, 2'h1);
    chk({watchdog_counter_clr, watchdog_prescaler_clr}, 2'h3);
    chk({halted, osc_run, busy}, 3'h5);
    @(negedge clk);
    {issue, wake} = 2'h1;
    chk({halted, watchdog_counter_clr, watchdog_prescaler_clr}, 3'h4);
    @(negedge clk);
    wake = 1'b0;
    chk({halted, osc_run, acc}, {2'h1, ea});
    print_verdict();
  end
  // the tests need well under a thousand cycles
  initial begin
    #100000;
    bad_count++;
    print_verdict();
  end
endmodule
`default_nettype wire

// ---- verilog/cie_alu.sv ----
// combinational arithmetic and logic unit for the accumulator operations
// assumes operands are stable for the cycle the opcode is presented
`default_nettype none
module cie_alu
  import cie_pkg::*;
#(
  parameter int W = CIE_DATA_W
) (
  // operation and operands
  input wire cie_op_t op,
  input wire logic [W-1:0] acc,
  input wire logic [W-1:0] lit,
  input wire logic [W-1:0] file_val,
  // result and flags
  output logic [W-1:0] result,
  output logic carry,
  output logic nibble_carry,
  output logic zero,
  output logic upd_carry,
  output logic upd_zero
);
  ////////////////////////////////////////////////////////////////////////////
  // subtract by adding inverse plus one; carry out is then not-borrow
  function automatic logic [W:0] sub_full(input logic [W-1:0] a, input logic [W-1:0] b);
    sub_full = {1'b0, a} + {1'b0, ~b} + {{W{1'b0}}, 1'b1};
  endfunction

  function automatic logic [CIE_NIB:0] sub_low(input logic [W-1:0] a, input logic [W-1:0] b);
    sub_low = {1'b0, a[CIE_NIB-1:0]} + {1'b0, ~b[CIE_NIB-1:0]} + {{CIE_NIB{1'b0}}, 1'b1};
  endfunction

  logic [W:0] diff;
  logic [CIE_NIB:0] low;
  logic [W-1:0] minuend;

  always_comb begin
    minuend = (op == CIE_OP_LITERAL_MINUS_ACC) ? lit : file_val;
    diff = sub_full(minuend, acc);
    low = sub_low(minuend, acc);
    carry = diff[W];
    nibble_carry = low[CIE_NIB];
    upd_carry = 1'b0;
    upd_zero = 1'b0;
    case (op)
      CIE_OP_LITERAL_MINUS_ACC, CIE_OP_FILE_MINUS_ACC: begin
        result = diff[W-1:0];
        upd_carry = 1'b1;
        upd_zero = 1'b1;
      end
      CIE_OP_LITERAL_XOR_ACC: begin
        result = acc ^ lit;
        upd_zero = 1'b1;
      end
      CIE_OP_FILE_XOR_ACC: begin
        result = acc ^ file_val;
        upd_zero = 1'b1;
      end
      CIE_OP_NIBBLE_EXCHANGE: begin
        result = {file_val[CIE_NIB-1:0], file_val[W-1:CIE_NIB]};
      end
      default: begin
        result = acc;
      end
    endcase
    zero = (result == CIE_ZERO[W-1:0]);
  end
endmodule
`default_nettype wire

// ---- verilog/cie_core_exec.sv ----
// execution of subroutine exit, halt and accumulator operations
// assumes the fetch logic holds off new instructions while busy is high
`default_nettype none
// Operation
// - subroutine exit pops the stack and loads the popped head into the pc, flags untouched.
// - subroutine exit takes two instruction cycles instead of one.
// - halt clears the powerdown flag and sets the timeout flag.
// - halt loads zero into the watchdog counter and clears its prescaler.
// - after halt the core enters the halted state with the oscillator stopped.
// - literal minus acc writes literal minus acc to acc and updates carry, digit carry, zero.
// - literal xor acc writes the xor to acc and updates only zero.
// - file minus acc computes file minus acc, updates three flags, dest bit picks target.
// - file xor acc computes the xor, updates only zero, dest bit picks target.
// - nibble exchange swaps file nibbles, changes no flags, dest bit picks target.
module cie_core_exec
  import cie_pkg::*;
#(
  parameter int W = CIE_DATA_W,
  parameter int AW = CIE_ADDR_W,
  parameter int PW = CIE_PC_W
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // instruction issue
  input wire logic issue,
  input wire cie_op_t op,
  input wire logic [W-1:0] literal,
  input wire logic [AW-1:0] file_addr,
  input wire logic dest_file,
  output logic busy,
  // wake from halt
  input wire logic wake,
  // register file
  input wire logic [W-1:0] file_rdata,
  output logic [AW-1:0] file_waddr,
  output logic [W-1:0] file_wdata,
  output logic file_we,
  // return stack and program counter
  input wire logic [PW-1:0] stack_head,
  output logic stack_pop,
  output logic [PW-1:0] pc_load_val,
  output logic pc_load,
  // watchdog
  output logic watchdog_counter_clr,
  output logic watchdog_prescaler_clr,
  // status and state
  output logic [W-1:0] acc,
  output logic carry_flag,
  output logic nibble_borrow_flag,
  output logic zero_flag,
  output logic timeout_flag,
  output logic powerdown_flag,
  output logic halted,
  output logic osc_run
);
  ////////////////////////////////////////////////////////////////////////////
  typedef enum logic [1:0] {CIE_RUN, CIE_EXIT2, CIE_HALTED} cie_state_t;

  typedef struct packed {
    cie_state_t st;
    logic [W-1:0] acc;
    logic c;
    logic dc;
    logic z;
    logic to;
    logic pd;
    logic [AW-1:0] waddr;
    logic [W-1:0] wdata;
    logic we;
    logic pop;
    logic [PW-1:0] pcv;
    logic pcl;
    logic wclr;
  } cie_core_t;

  cie_core_t s_r, s_nxt;

  // reset image; timeout and powerdown read high, and a halt clears only powerdown
  localparam cie_core_t CORE_RST = '{
    st: CIE_RUN,
    acc: W'(CIE_ACC_RST),
    c: 1'b0,
    dc: 1'b0,
    z: 1'b0,
    to: CIE_TO_RST,
    pd: CIE_PD_RST,
    waddr: '0,
    wdata: '0,
    we: 1'b0,
    pop: 1'b0,
    pcv: '0,
    pcl: 1'b0,
    wclr: 1'b0
  };

  logic [W-1:0] alu_res;
  logic alu_c;
  logic alu_dc;
  logic alu_z;
  logic upd_c;
  logic upd_z;

  ////////////////////////////////////////////////////////////////////////////
  // literal forms carry no file operand, so they always land in acc
  function automatic logic to_file(input cie_op_t o, input logic d);
    to_file = d && (o inside {CIE_OP_FILE_MINUS_ACC, CIE_OP_FILE_XOR_ACC,
      CIE_OP_NIBBLE_EXCHANGE});
  endfunction

  // halted and the oscillator enable read the same decode
  function automatic logic is_halted(input cie_state_t st);
    is_halted = (st == CIE_HALTED);
  endfunction

  cie_alu #(.W(W)) u_alu (
    .op(op),
    .acc(s_r.acc),
    .lit(literal),
    .file_val(file_rdata),
    .result(alu_res),
    .carry(alu_c),
    .nibble_carry(alu_dc),
    .zero(alu_z),
    .upd_carry(upd_c),
    .upd_zero(upd_z)
  );

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    s_nxt = s_r;
    // strobes last one cycle
    s_nxt.we = 1'b0;
    s_nxt.pop = 1'b0;
    s_nxt.pcl = 1'b0;
    s_nxt.wclr = 1'b0;
    case (s_r.st)
      CIE_RUN: begin
        if (issue) begin
          case (op)
            CIE_OP_SUB_EXIT: begin
              s_nxt.pop = 1'b1;
              s_nxt.pcv = stack_head;
              s_nxt.pcl = 1'b1;
              s_nxt.st = CIE_EXIT2;
            end
            CIE_OP_HALT: begin
              s_nxt.pd = 1'b0;
              s_nxt.to = 1'b1;
              s_nxt.wclr = 1'b1;
              s_nxt.st = CIE_HALTED;
            end
            CIE_OP_LITERAL_MINUS_ACC, CIE_OP_LITERAL_XOR_ACC, CIE_OP_FILE_MINUS_ACC,
            CIE_OP_FILE_XOR_ACC, CIE_OP_NIBBLE_EXCHANGE: begin
              // literal forms always target acc
              if (to_file(op, dest_file)) begin
                s_nxt.we = 1'b1;
                s_nxt.waddr = file_addr;
                s_nxt.wdata = alu_res;
              end else begin
                s_nxt.acc = alu_res;
              end
              if (upd_c) begin
                s_nxt.c = alu_c;
                s_nxt.dc = alu_dc;
              end
              if (upd_z) begin
                s_nxt.z = alu_z;
              end
            end
            default: begin
              s_nxt.st = CIE_RUN;
            end
          endcase
        end
      end
      CIE_EXIT2: begin
        // second cycle refills fetch from the new pc
        s_nxt.st = CIE_RUN;
      end
      CIE_HALTED: begin
        // flags left for the wake source to update
        if (wake) begin
          s_nxt.st = CIE_RUN;
        end
      end
      default: begin
        s_nxt.st = CIE_RUN;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      s_r <= CORE_RST;
    end else begin
      s_r <= s_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  assign busy = (s_r.st != CIE_RUN);
  assign file_waddr = s_r.waddr;
  assign file_wdata = s_r.wdata;
  assign file_we = s_r.we;
  assign stack_pop = s_r.pop;
  assign pc_load_val = s_r.pcv;
  assign pc_load = s_r.pcl;
  // one pulse clears both, so no stale prescale survives the halt
  assign watchdog_counter_clr = s_r.wclr;
  assign watchdog_prescaler_clr = s_r.wclr;
  assign acc = s_r.acc;
  assign carry_flag = s_r.c;
  assign nibble_borrow_flag = s_r.dc;
  assign zero_flag = s_r.z;
  assign timeout_flag = s_r.to;
  assign powerdown_flag = s_r.pd;
  assign halted = is_halted(s_r.st);
  assign osc_run = !is_halted(s_r.st);
endmodule
`default_nettype wire

// ---- verilog/cie_pkg.sv ----
// constants and types for the instruction subset execution block
// assumes a single 10 MHz instruction clock shared with the core
`default_nettype none
package cie_pkg;
  localparam int CIE_DATA_W = 8;
  localparam int CIE_ADDR_W = 7;
  localparam int CIE_PC_W = 13;
  localparam int CIE_WDT_W = 8;
  localparam int CIE_PRE_W = 8;
  localparam logic [7:0] CIE_ACC_RST = 8'h00;
  localparam logic CIE_TO_RST = 1'b1;
  localparam logic CIE_PD_RST = 1'b1;
  localparam logic [7:0] CIE_WDT_CLR = 8'h00;
  localparam logic [7:0] CIE_PRE_CLR = 8'h00;
  localparam logic [7:0] CIE_ZERO = 8'h00;
  localparam int CIE_NIB = 4;
  localparam int CIE_EXIT_CYCLES = 2;
  // operation selector presented with each instruction
  typedef enum logic [2:0] {
    CIE_OP_NONE,
    CIE_OP_SUB_EXIT,
    CIE_OP_HALT,
    CIE_OP_LITERAL_MINUS_ACC,
    CIE_OP_LITERAL_XOR_ACC,
    CIE_OP_FILE_MINUS_ACC,
    CIE_OP_FILE_XOR_ACC,
    CIE_OP_NIBBLE_EXCHANGE
  } cie_op_t;
endpackage
`default_nettype wire
